/* hw/nvs_cfg.svh */
// Purpose: Constants for the non-volatile program sequencer
// Assumes: Byte-wide register space reached through an internal write/read port
// Notes:   Timing counts derived for a 10 MHz core clock
`ifndef NVS_CFG_SVH
`define NVS_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define NVS_WORK_FIRST      8'h07
`define NVS_WORK_LAST       8'h15
`define NVS_STORE_FIRST     8'h17
`define NVS_STORE_LAST      8'h25
`define NVS_BURN_ADDR       8'h78
`define NVS_RELOAD_ADDR     8'h79
`define NVS_STATUS_ADDR     8'h7b
`define NVS_CTRL_ADDR       8'h7c
`define NVS_WORK_COUNT      15
// ----------------------------------------
// Field positions and resets
// ----------------------------------------
`define NVS_FAULT_BIT       0
`define NVS_BUSY_BIT        1
`define NVS_ARF_BIT         0
`define NVS_PAR_BIT         1
`define NVS_CTRL_RESET      8'h00
`define NVS_MAX_BURNS       5
// ----------------------------------------
// Timing
// ----------------------------------------
`define NVS_CLK_HZ          10000000
`define NVS_BURN_TIME_MS    20
`define NVS_BURN_CYCLES     ((`NVS_CLK_HZ / 1000) * `NVS_BURN_TIME_MS)
`define NVS_REFRESH_MS      100
`define NVS_REFRESH_CYCLES  ((`NVS_CLK_HZ / 1000) * `NVS_REFRESH_MS)

`endif

/* hw/nvs_pkg.sv */
// Purpose: Types for the non-volatile program sequencer
// Assumes: Constants come from nvs_cfg.svh
// Notes:   None
package nvs_pkg;
  // Host register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nvs_req_type;

  typedef enum logic [1:0] {
    NVS_IDLE,
    NVS_BURN,
    NVS_RELOAD
  } nvs_state_type;
endpackage

/* hw/nvs_store.sv */
// Purpose: Non-volatile array model with life counter
// Assumes: One word written or read per cycle
// Notes:   Writes beyond the life limit are refused
`timescale 1ns/10ps
`default_nettype none
`include "nvs_cfg.svh"
module nvs_store #(
  parameter int WORDS     = `NVS_WORK_COUNT,
  parameter int MAX_BURNS = `NVS_MAX_BURNS
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Word access
  input  wire logic       wr_i,
  input  wire logic [3:0] idx_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  // Life accounting
  input  wire logic       burn_done_i,
  output logic            exhausted_o
);
  logic [7:0] mem_r [WORDS];
  logic [2:0] burns_r;

  always_ff @(posedge core_clk_i) begin
    if (wr_i && !exhausted_o) begin
      mem_r[idx_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_r[idx_i];

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      burns_r <= 3'h0;
    end else if (burn_done_i && !exhausted_o) begin
      burns_r <= burns_r + 3'h1;
    end
  end

  assign exhausted_o = (burns_r >= 3'(MAX_BURNS));
endmodule
`default_nettype wire

/* hw/nvs_seq.sv */
// Purpose: Burn, reload and auto-refresh sequencing of the working registers
// Assumes: Host writes and reads arrive as single-cycle strobes
// Notes:   Working registers live here; burn stores them, reload restores them
//
// Overview of operation
// - Burn copies working 0x07..0x15 into stored 0x17..0x25.
// - A write to 0x78 while idle starts a burn.
// - Fault flag reads 0 on success, 1 on failure, checked after 20 ms.
// - A write to 0x79 while idle reloads working registers from storage.
// - Storage accepts at most five programming operations.
// - Auto-refresh periodically restores working registers from storage.
`timescale 1ns/10ps
`default_nettype none
`include "nvs_cfg.svh"
module nvs_seq #(
  parameter int BURN_CYCLES    = `NVS_BURN_CYCLES,
  parameter int REFRESH_CYCLES = `NVS_REFRESH_CYCLES,
  parameter int MAX_BURNS      = `NVS_MAX_BURNS
) (
  // Clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  // Host register access
  input  wire nvs_pkg::nvs_req_type req_i,
  output logic               [7:0] rdata_o,
  output logic                     rvalid_o,
  // Programming supply status
  input  wire logic                programming_supply_pin_i,
  // Status
  output logic                     program_fault_flag_o,
  output logic                     busy_o
);
  localparam int WORDS = `NVS_WORK_COUNT;

  // ----------------------------------------
  // State
  // ----------------------------------------
  nvs_pkg::nvs_state_type state_r;
  logic [7:0]  work_r [WORDS];
  logic [7:0]  ctrl_r;
  logic [3:0]  idx_r;
  logic [31:0] wait_r;
  logic [31:0] refresh_r;
  logic        fault_r;
  logic        bad_r;
  logic        st_wr;
  logic        st_exh;
  logic [7:0]  st_rdata;
  logic        burn_req;
  logic        reload_req;
  logic        in_work;
  logic [3:0]  widx;
  logic        copy_last;
  logic        par_bad;
  logic        in_store;
  logic [3:0]  sidx;
  logic [3:0]  st_idx;

  assign burn_req   = req_i.wr && (req_i.addr == `NVS_BURN_ADDR);
  assign reload_req = req_i.wr && (req_i.addr == `NVS_RELOAD_ADDR);
  assign in_work    = (req_i.addr >= `NVS_WORK_FIRST) && (req_i.addr <= `NVS_WORK_LAST);
  assign widx       = 4'(req_i.addr - `NVS_WORK_FIRST);
  assign copy_last  = (idx_r == 4'(WORDS - 1));
  assign in_store   = (req_i.addr >= `NVS_STORE_FIRST) && (req_i.addr <= `NVS_STORE_LAST);
  assign sidx       = 4'(req_i.addr - `NVS_STORE_FIRST);
  // Idle reads of the stored copy borrow the array index
  assign st_idx     = (state_r == nvs_pkg::NVS_IDLE && req_i.rd && in_store) ? sidx : idx_r;
  assign st_wr      = (state_r == nvs_pkg::NVS_BURN) && (wait_r == 32'h0) && !bad_r;

  always_comb begin
    par_bad = 1'b0;
    for (int i = 0; i < WORDS; i++) begin
      par_bad = par_bad ^ (^work_r[i]);
    end
  end

  nvs_store #(
    .WORDS     (WORDS),
    .MAX_BURNS (MAX_BURNS)
  ) u_store (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .wr_i        (st_wr),
    .idx_i       (st_idx),
    .wdata_i     (work_r[idx_r]),
    .rdata_o     (st_rdata),
    .burn_done_i (st_wr && copy_last),
    .exhausted_o (st_exh)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r <= nvs_pkg::NVS_IDLE;
      idx_r   <= 4'h0;
      wait_r  <= 32'h0;
      fault_r <= 1'b0;
      bad_r   <= 1'b0;
    end else begin
      case (state_r)
        nvs_pkg::NVS_IDLE: begin
          if (burn_req) begin
            state_r <= nvs_pkg::NVS_BURN;
            idx_r   <= 4'h0;
            wait_r  <= 32'h0;
            bad_r   <= st_exh || !programming_supply_pin_i
                       || (ctrl_r[`NVS_PAR_BIT] && par_bad);
          end else if (reload_req) begin
            state_r <= nvs_pkg::NVS_RELOAD;
            idx_r   <= 4'h0;
          end else if (ctrl_r[`NVS_ARF_BIT] && refresh_r == 32'(REFRESH_CYCLES - 1)) begin
            state_r <= nvs_pkg::NVS_RELOAD;
            idx_r   <= 4'h0;
          end
        end
        nvs_pkg::NVS_BURN: begin
          if (wait_r == 32'h0 && !copy_last) begin
            idx_r <= idx_r + 4'h1;
          end else if (wait_r == 32'(BURN_CYCLES - 1)) begin
            state_r <= nvs_pkg::NVS_IDLE;
            fault_r <= bad_r;
          end
          if (wait_r != 32'h0 || copy_last) begin
            wait_r <= wait_r + 32'h1;
          end
        end
        nvs_pkg::NVS_RELOAD: begin
          idx_r <= idx_r + 4'h1;
          if (copy_last) begin
            state_r <= nvs_pkg::NVS_IDLE;
          end
        end
        default: state_r <= nvs_pkg::NVS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Working registers and control
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < WORDS; i++) begin
        work_r[i] <= 8'h00;
      end
    end else if (state_r == nvs_pkg::NVS_RELOAD) begin
      work_r[idx_r] <= st_rdata;
    end else if (state_r == nvs_pkg::NVS_IDLE && req_i.wr && in_work) begin
      work_r[widx] <= req_i.wdata;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_r <= `NVS_CTRL_RESET;
    end else if (req_i.wr && req_i.addr == `NVS_CTRL_ADDR) begin
      ctrl_r <= req_i.wdata;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !ctrl_r[`NVS_ARF_BIT] || state_r != nvs_pkg::NVS_IDLE) begin
      refresh_r <= 32'h0;
    end else begin
      refresh_r <= refresh_r + 32'h1;
    end
  end

  // ----------------------------------------
  // Read path and outputs
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o              <= 8'h00;
      rvalid_o             <= 1'b0;
      program_fault_flag_o <= 1'b0;
      busy_o               <= 1'b0;
    end else begin
      rvalid_o             <= req_i.rd;
      program_fault_flag_o <= fault_r;
      busy_o               <= (state_r != nvs_pkg::NVS_IDLE);
      if (req_i.rd) begin
        if (in_work) begin
          rdata_o <= work_r[widx];
        end else if (in_store && state_r == nvs_pkg::NVS_IDLE) begin
          rdata_o <= st_rdata;
        end else if (req_i.addr == `NVS_STATUS_ADDR) begin
          rdata_o <= {6'h00, state_r != nvs_pkg::NVS_IDLE, fault_r};
        end else if (req_i.addr == `NVS_CTRL_ADDR) begin
          rdata_o <= ctrl_r;
        end else begin
          rdata_o <= 8'h00;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/nvs_seq_monitor.sv */
// Purpose: Port checks for nvs_seq
// Assumes: Short sim burn, under 60 cycles
// Notes:   Bound from the bench top
`timescale 1ns/10ps
`default_nettype none
module nvs_seq_monitor #(
  parameter int MAX_BURNS = 5
) (
  input wire logic                 core_clk_i,
  input wire logic                 rst_i,
  input wire nvs_pkg::nvs_req_type req_i,
  input wire logic [7:0]           rdata_o,
  input wire logic                 rvalid_o,
  input wire logic                 programming_supply_pin_i,
  input wire logic                 program_fault_flag_o,
  input wire logic                 busy_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic       burn;
  logic       reld;
  logic       burn_r;
  logic       busy_q;
  logic [3:0] good_r;
  assign burn = req_i.wr && req_i.addr == 8'h78 && !busy_o;
  assign reld = req_i.wr && req_i.addr == 8'h79 && !busy_o;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) busy_q <= 1'b0;
    else busy_q <= busy_o;
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) burn_r <= 1'b0;
    else if (burn) burn_r <= 1'b1;
    else if (busy_q && !busy_o) burn_r <= 1'b0;
  end
  // Successful burns seen so far
  always_ff @(posedge core_clk_i) begin
    if (rst_i) good_r <= 4'h0;
    else if (burn_r && busy_q && !busy_o && !program_fault_flag_o) good_r <= good_r + 4'h1;
  end
  burn_start_a: assert property (burn |-> ##2 busy_o)
    else $error("burn did not start");
  reload_start_a: assert property (reld |-> ##2 busy_o)
    else $error("reload did not start");
  burn_end_a: assert property (burn |-> ##[2:60] !busy_o)
    else $error("burn did not end");
  dry_fault_a: assert property (burn && !programming_supply_pin_i
    |-> ##[2:60] ($fell(busy_o) && program_fault_flag_o)) else $error("no fault");
  worn_fault_a: assert property (burn && int'(good_r) == MAX_BURNS
    |-> ##[2:60] ($fell(busy_o) && program_fault_flag_o)) else $error("worn burn ok");
  life_limit_a: assert property (int'(good_r) <= MAX_BURNS)
    else $error("too many burns");
  flag_hold_a: assert property (!busy_o && !$past(busy_o)
    |-> $stable(program_fault_flag_o)) else $error("flag moved");
  read_answer_a: assert property (req_i.rd |=> rvalid_o)
    else $error("no read answer");
  cover property (burn);
  cover property (reld);
  cover property ($fell(busy_o) && program_fault_flag_o);
endmodule
`default_nettype wire

/* testbench/nvs_host.sv */
// Purpose: Host model on the register port
// Assumes: One request at a time
// Notes:   img holds the image last loaded
`timescale 1ns/10ps
`default_nettype none
module nvs_host (
  input  wire logic                core_clk_i,
  output var nvs_pkg::nvs_req_type req_o,
  input  wire logic [7:0]          rdata_i,
  input  wire logic                rvalid_i
);
  logic [7:0] img [15];
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    #1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    #1 req_o = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    #1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk_i);
    #1 req_o = '0;
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
  endtask
  // Fill working range, last byte evens parity
  task automatic load(input logic [7:0] b);
    logic p;
    p = 1'b0;
    for (int i = 0; i < 15; i++) begin
      img[i] = b + 8'(i);
      if (i == 14) img[i][0] = img[i][0] ^ p ^ (^img[i]);
      p = p ^ (^img[i]);
      wr(8'h07 + 8'(i), img[i]);
    end
  endtask
endmodule
`default_nettype wire

/* testbench/test_nvs_seq.sv */
// Purpose: Self-checking bench for nvs_seq
// Assumes: Burn 20 cycles, refresh 50 cycles
// Notes:   Scenarios run in order, life count carries over
`timescale 1ns/10ps
`default_nettype none
module test_nvs_seq;
  logic                 core_clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 sup = 1'b0;
  nvs_pkg::nvs_req_type req;
  logic [7:0]           rdata;
  logic [7:0]           v;
  logic                 rvalid;
  logic                 fault;
  logic                 busy;
  int                   failures = 0;
  int                   check_count = 0;
  int                   cyc = 0;
  nvs_seq #(.BURN_CYCLES(20), .REFRESH_CYCLES(50), .MAX_BURNS(5)) nvs_seq_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
    .rvalid_o(rvalid), .programming_supply_pin_i(sup),
    .program_fault_flag_o(fault), .busy_o(busy));
  nvs_host nvs_host_inst (
    .core_clk_i(core_clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));
  initial forever #50 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic give_verdict;
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic burn(input logic f);
    int n;
    n = 0;
    nvs_host_inst.wr(8'h78, 8'h5a);
    while (busy !== 1'b1 && n < 5) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    chk({7'h0, busy}, 8'h01);
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    chk({7'h0, fault}, {7'h0, f});
    nvs_host_inst.rd(8'h7b, v);
    chk(v, {7'h0, f});
  endtask
  task automatic stored;
    for (int i = 0; i < 15; i++) begin
      nvs_host_inst.rd(8'h17 + 8'(i), v);
      chk(v, nvs_host_inst.img[i]);
    end
  endtask
  task automatic t_first;
    nvs_host_inst.rd(8'h7c, v);
    chk(v, 8'h00);
    nvs_host_inst.rd(8'h50, v);
    chk(v, 8'h00);
    sup = 1'b1;
    nvs_host_inst.load(8'h10);
    burn(1'b0);
    stored();
  endtask
  task automatic t_dry;
    sup = 1'b0;
    nvs_host_inst.wr(8'h07, 8'hee);
    burn(1'b1);
    stored();
    nvs_host_inst.wr(8'h07, nvs_host_inst.img[0]);
    sup = 1'b1;
    burn(1'b0);
    nvs_host_inst.wr(8'h07, 8'h99);
    nvs_host_inst.wr(8'h79, 8'h00);
    repeat (20) @(posedge core_clk_i);
    nvs_host_inst.rd(8'h07, v);
    chk(v, nvs_host_inst.img[0]);
  endtask
  task automatic t_life;
    nvs_host_inst.wr(8'h7c, 8'h02);
    for (int k = 0; k < 3; k++) begin
      nvs_host_inst.load(8'h40 + 8'(k * 16));
      burn(1'b0);
    end
    nvs_host_inst.wr(8'h7c, 8'h00);
    nvs_host_inst.wr(8'h07, 8'h77);
    burn(1'b1);
    stored();
    nvs_host_inst.wr(8'h7c, 8'h01);
    for (int n = 0; n < 40 && v !== nvs_host_inst.img[0]; n++) nvs_host_inst.rd(8'h07, v);
    chk(v, nvs_host_inst.img[0]);
    nvs_host_inst.load(8'h21);
    burn(1'b1);
    nvs_host_inst.wr(8'h7c, 8'h00);
    nvs_host_inst.rd(8'h7c, v);
    chk(v, 8'h00);
  endtask
  initial begin
    repeat (3) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    nvs_host_inst.rd(8'h7b, v);
    chk(v, 8'h00);
    t_first();
    t_dry();
    t_life();
    give_verdict();
  end
endmodule
bind nvs_seq nvs_seq_monitor #(.MAX_BURNS(MAX_BURNS)) nvs_seq_monitor_inst (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .programming_supply_pin_i(programming_supply_pin_i),
  .program_fault_flag_o(program_fault_flag_o), .busy_o(busy_o));
`default_nettype wire
